// ---- inc/bst_defs.vh ----
/*
  Constants of the boundary-scan test port: instruction codes, register
  lengths and identification word fields.
  Assumes inclusion by bare name from the design files.
*/
`ifndef BST_DEFS_VH
`define BST_DEFS_VH

// ==================================================
// Instruction register
`define BST_IR_W 4
`define BST_IR_EXTEST 4'h0
`define BST_IR_SAMPLE 4'h1
`define BST_IR_IDCODE 4'h2
`define BST_IR_CLAMP 4'h3
`define BST_IR_HIGHZ 4'h4
`define BST_IR_BYPASS 4'hF
`define BST_IR_CAPTURE 4'h1

// ==================================================
// Identification word fields
`define BST_ID_W 32
`define BST_ID_REV_HI 31
`define BST_ID_REV_LO 28
`define BST_ID_PART_HI 27
`define BST_ID_PART_LO 12
`define BST_ID_MAKER_HI 11
`define BST_ID_MAKER_LO 1
`define BST_ID_LSB 0

// ==================================================
// Boundary chain: one cell per core input, two per output (data, enable)
`define BST_NIN 4
`define BST_NOUT 4
`define BST_BSR_W 12

`endif

// ---- core/bst_tap.v ----
/*
  Boundary-scan test access port with instruction register, bypass,
  identification register and boundary chain over sampled pins.
  Assumes the test pins arrive asynchronously to ref_clk and that the test
  clock is much slower than ref_clk so its edges can be found by sampling.
*/
// Function
// RL1: Five-signal test port: test clock, mode select, data in, data out, test reset.
// RL2: Sample/preload captures pin values into the chain and lets preset values shift in.
// RL3: External test drives pins from boundary values shifted in earlier.
// RL4: Bypass puts a one-bit register between data in and data out.
// RL5: Identification instruction shifts the 32-bit identification word out.
// RL6: Clamp forces preset boundary values onto output pins.
// RL7: High-impedance instruction releases every output pin.
// RL8: Bits 31 to 28 hold the revision, starting at one.
// RL9: Bits 27 to 12 hold the fixed sixteen-bit part number.
// RL10: Bits 11 to 1 hold the maker code; bit 0 is one.
// RL11: Host programs identical host_latency_setting into all engines of a bank.
// RL12: Controller holds test reset low until both supplies settle.
// RL13: Standard sixteen-state controller; sample on rising, drive data out on falling edge.
// RL14: Own opcodes, all-ones bypass, identification selected after test reset.
`timescale 1ns/1ps
`default_nettype none
`include "bst_defs.vh"

module bst_tap #(
  parameter [3:0] REVISION = 4'h1,       // Arbitrary value
  parameter [15:0] PART_CODE = 16'h5A5A, // Arbitrary value
  parameter [10:0] MAKER_CODE = 11'h2A5  // Arbitrary value
) (
  input wire ref_clk,
  input wire rst_n,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  output reg tdo,
  output reg tdo_oe,
  input wire [`BST_NIN-1:0] pin_in,
  input wire [`BST_NOUT-1:0] core_out,
  input wire [`BST_NOUT-1:0] core_oe,
  output reg [`BST_NOUT-1:0] pin_out,
  output reg [`BST_NOUT-1:0] pin_oe
);

  // TAP states, standard encoding order
  localparam [3:0] S_RESET = 4'h0, S_IDLE = 4'h1, S_SEL_DR = 4'h2, S_CAP_DR = 4'h3,
    S_SH_DR = 4'h4, S_EX1_DR = 4'h5, S_PA_DR = 4'h6, S_EX2_DR = 4'h7, S_UP_DR = 4'h8,
    S_SEL_IR = 4'h9, S_CAP_IR = 4'hA, S_SH_IR = 4'hB, S_EX1_IR = 4'hC, S_PA_IR = 4'hD,
    S_EX2_IR = 4'hE, S_UP_IR = 4'hF;

  // ==================================================
  // Input synchronisers
  reg [7:0] sy1_r;
  reg [7:0] sy2_r;
  reg tck_d_r;
  // All async pins, boundary inputs included, pass two flops before use
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy1_r <= 8'h00;
      sy2_r <= 8'h00;
      tck_d_r <= 1'b0;
    end
    else
    begin
      sy1_r <= {pin_in, trst_n, tck, tms, tdi};
      sy2_r <= sy1_r;
      tck_d_r <= sy2_r[2];
    end
  end

  wire trst_s_n = sy2_r[3];
  wire tck_s = sy2_r[2];
  wire tms_s = sy2_r[1];
  wire tdi_s = sy2_r[0];
  wire [`BST_NIN-1:0] pin_in_s = sy2_r[7:4]; // Captured pin levels, two flops late
  wire tck_rise = tck_s & ~tck_d_r; // see RL13
  wire tck_fall = ~tck_s & tck_d_r; // see RL13

  // ==================================================
  // Next-state function of the controller
  function [3:0] bst_next;
    input [3:0] st;
    input m;
    begin
      case (st)
        S_RESET: bst_next = m ? S_RESET : S_IDLE;
        S_IDLE: bst_next = m ? S_SEL_DR : S_IDLE;
        S_SEL_DR: bst_next = m ? S_SEL_IR : S_CAP_DR;
        S_CAP_DR: bst_next = m ? S_EX1_DR : S_SH_DR;
        S_SH_DR: bst_next = m ? S_EX1_DR : S_SH_DR;
        S_EX1_DR: bst_next = m ? S_UP_DR : S_PA_DR;
        S_PA_DR: bst_next = m ? S_EX2_DR : S_PA_DR;
        S_EX2_DR: bst_next = m ? S_UP_DR : S_SH_DR;
        S_UP_DR: bst_next = m ? S_SEL_DR : S_IDLE;
        S_SEL_IR: bst_next = m ? S_RESET : S_CAP_IR;
        S_CAP_IR: bst_next = m ? S_EX1_IR : S_SH_IR;
        S_SH_IR: bst_next = m ? S_EX1_IR : S_SH_IR;
        S_EX1_IR: bst_next = m ? S_UP_IR : S_PA_IR;
        S_PA_IR: bst_next = m ? S_EX2_IR : S_PA_IR;
        S_EX2_IR: bst_next = m ? S_UP_IR : S_SH_IR;
        S_UP_IR: bst_next = m ? S_SEL_DR : S_IDLE;
        default: bst_next = S_RESET;
      endcase
    end
  endfunction

  reg [3:0] state_r;
  reg [`BST_IR_W-1:0] ir_sh_r;
  reg [`BST_IR_W-1:0] ir_r;
  reg bypass_r;
  reg [`BST_ID_W-1:0] id_sh_r;
  reg [`BST_BSR_W-1:0] bsr_sh_r;
  reg [`BST_BSR_W-1:0] bsr_up_r;

  wire [`BST_ID_W-1:0] id_word = {REVISION, PART_CODE, MAKER_CODE, 1'b1}; // see RL8 RL9 RL10
  wire [`BST_BSR_W-1:0] pin_snap = {core_oe, core_out, pin_in_s};
  wire ir_bsr = (ir_r == `BST_IR_EXTEST) || (ir_r == `BST_IR_SAMPLE) ||
    (ir_r == `BST_IR_CLAMP);

  // ==================================================
  // Controller and scan registers, updated on rising test clock
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= S_RESET;
      ir_sh_r <= `BST_IR_CAPTURE;
      ir_r <= `BST_IR_IDCODE;
      bypass_r <= 1'b0;
      id_sh_r <= {`BST_ID_W{1'b0}};
      bsr_sh_r <= {`BST_BSR_W{1'b0}};
      bsr_up_r <= {`BST_BSR_W{1'b0}};
    end
    else if (!trst_s_n)
    begin
      // Test reset forces the reset state; chain contents are kept
      state_r <= S_RESET; // see RL1
      ir_r <= `BST_IR_IDCODE; // see RL14
    end
    else if (tck_rise)
    begin
      state_r <= bst_next(state_r, tms_s); // see RL13
      case (state_r)
        S_RESET: ir_r <= `BST_IR_IDCODE; // see RL14
        S_CAP_IR: ir_sh_r <= `BST_IR_CAPTURE;
        S_SH_IR: ir_sh_r <= {tdi_s, ir_sh_r[`BST_IR_W-1:1]};
        S_UP_IR: ir_r <= ir_sh_r;
        S_CAP_DR:
        begin
          bypass_r <= 1'b0; // see RL4
          id_sh_r <= id_word; // see RL5
          if (ir_bsr)
            bsr_sh_r <= pin_snap; // see RL2
        end
        S_SH_DR:
        begin
          bypass_r <= tdi_s; // see RL4
          id_sh_r <= {tdi_s, id_sh_r[`BST_ID_W-1:1]}; // see RL5
          bsr_sh_r <= {tdi_s, bsr_sh_r[`BST_BSR_W-1:1]}; // see RL2
        end
        S_UP_DR:
          if (ir_bsr)
            bsr_up_r <= bsr_sh_r; // Preload for later external test, see RL2 RL3
        default: state_r <= bst_next(state_r, tms_s);
      endcase
    end
  end

  // ==================================================
  // Data out changes on the falling test clock edge
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (!trst_s_n)
    begin
      tdo <= 1'b0; // see RL1
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_oe <= (state_r == S_SH_DR) || (state_r == S_SH_IR); // see RL13
      if (state_r == S_SH_IR)
        tdo <= ir_sh_r[0];
      else if (state_r != S_SH_DR)
        tdo <= 1'b0; // Quiet while the enable is low, so a released pin never shows stale data
      else if (ir_r == `BST_IR_IDCODE)
        tdo <= id_sh_r[0]; // see RL5
      else if (ir_bsr)
        tdo <= bsr_sh_r[0];
      else
        tdo <= bypass_r; // Unused opcodes behave as bypass, see RL4
    end
  end

  // ==================================================
  // Pin multiplexer; output registered, so pins lag the core by one cycle
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out <= {`BST_NOUT{1'b0}};
      pin_oe <= {`BST_NOUT{1'b0}};
    end
    else if (ir_r == `BST_IR_HIGHZ)
    begin
      pin_out <= core_out;
      pin_oe <= {`BST_NOUT{1'b0}}; // see RL7
    end
    else if ((ir_r == `BST_IR_EXTEST) || (ir_r == `BST_IR_CLAMP))
    begin
      // Clamp reuses the preloaded update stage, see RL3 RL6
      pin_out <= bsr_up_r[2*`BST_NOUT-1:`BST_NOUT];
      pin_oe <= bsr_up_r[`BST_BSR_W-1:2*`BST_NOUT];
    end
    else
    begin
      pin_out <= core_out;
      pin_oe <= core_oe;
    end
  end

endmodule // bst_tap

`default_nettype wire

// ---- testbench/bst_tap_monitor.sv ----
/* Output checks of the test port.
   Assumes a bind to bst_tap, tck far slower than ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module bst_tap_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [3:0] pin_in,
  input wire logic [3:0] core_out,
  input wire logic [3:0] core_oe,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe
);
  // ==========
  // One domain, so one clock and one disable
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  chk_tdo_quiet: assert property (!tdo_oe |-> !tdo) else $error("tdo high while idle");
  chk_tdo_hold: assert property (tck && $past(tck) |-> $stable(tdo)) else $error("tdo moved");
  chk_tdo_settle: assert property ($stable(tck)[*5] |-> $stable(tdo)) else $error("tdo late");
  chk_trst_oe: assert property ((!trst_n)[*5] |-> !tdo_oe) else $error("oe in reset");
  chk_trst_tdo: assert property ((!trst_n)[*5] |-> !tdo) else $error("tdo in reset");
  chk_func_out: assert property ((!trst_n)[*6] |=> pin_out == $past(core_out))
    else $error("pin_out not functional");
  chk_func_oe: assert property ((!trst_n)[*6] |=> pin_oe == $past(core_oe))
    else $error("pin_oe not functional");
  chk_reset_out: assert property ($rose(rst_n) |-> !tdo_oe && !tdo && pin_oe == 4'h0)
    else $error("outputs not cleared");
  // Main scenarios reached
  cover property ($rose(tdo_oe));
  cover property (tdo_oe && tdo);
  cover property ($fell(trst_n));
endmodule // bst_tap_monitor
bind bst_tap bst_tap_monitor mon_u (.ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .tms(tms),
  .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in),
  .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// ---- testbench/bst_ctl_model.sv ----
/* Model of the external test controller.
   Assumes a 400 ns test clock that stands low between frames. */
`timescale 1ns/1ps
`default_nettype none
module bst_ctl_model (
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  output var logic trst_n,
  input wire logic tdo
);
  // ==========
  // The latency setting of a bank is host work, never sent through this port
  // Power-up: test reset held low until released on purpose
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
  end
  // One period; tdo read late in the low phase, long after its fall update
  task automatic tick(input logic m, input logic d, output logic o);
  begin
    tms = m;
    tdi = d;
    #200;
    o = tdo;
    tck = 1'b1;
    #200;
    tck = 1'b0;
  end
  endtask
  // Test reset pulse, then five ones and park in Idle
  task automatic reset_tap;
    logic o;
  begin
    trst_n = 1'b0;
    #500;
    trst_n = 1'b1;
    #200;
    repeat (5) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  end
  endtask
  // Idle to Idle scan of n bits, first bit in and out is bit 0
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic o;
  begin
    dout = 32'h0;
    tick(1'b1, 1'b0, o);
    if (ir)
      tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  end
  endtask
endmodule // bst_ctl_model
`default_nettype wire

// ---- testbench/bst_tap_bench.sv ----
/* Self-checking bench of the test port.
   Assumes bst_tap, its checker and the controller model compiled first. */
`timescale 1ns/1ps
`default_nettype none
module bst_tap_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] pin_in = 4'h0, core_out = 4'h0, core_oe = 4'h0;
  wire tck, tms, tdi, trst_n, tdo, tdo_oe;
  wire [3:0] pin_out, pin_oe;
  logic [31:0] got;
  int mismatches = 0, compares = 0, cycles = 0;
  // ==========
  // Clock, units and timeout
  always #25 ref_clk = ~ref_clk;
  bst_tap dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out),
    .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));
  bst_ctl_model ctl_u (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));
  // Whole run needs about 1400 cycles; the ceiling leaves a wide margin
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  // ==========
  // Compare and close
  task automatic check(input logic [31:0] g, input logic [31:0] e);
  begin
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  end
  endtask
  task automatic wrap_up;
  begin
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // ==========
  // Sequence: identity, sample, drive modes, bypass, test reset
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    ctl_u.reset_tap();
    ctl_u.scan(1'b0, 32, 32'h0, got);
    check(got, {4'h1, 16'h5A5A, 11'h2A5, 1'b1});
    @(posedge ref_clk) #1 {core_oe, core_out, pin_in} = 12'hC69;
    ctl_u.scan(1'b1, 4, 32'h1, got);
    check(got, 32'h1);
    ctl_u.scan(1'b0, 12, 32'hABC, got);
    check(got, 32'hC69);
    ctl_u.scan(1'b1, 4, 32'h0, got);
    check({pin_oe, pin_out}, 8'hAB);
    ctl_u.scan(1'b1, 4, 32'h3, got);
    check({pin_oe, pin_out}, 8'hAB);
    ctl_u.scan(1'b1, 4, 32'h4, got);
    check(pin_oe, 4'h0);
    ctl_u.scan(1'b1, 4, 32'hF, got);
    ctl_u.scan(1'b0, 8, 32'hA5, got);
    check(got, 32'h4A);
    ctl_u.reset_tap();
    check({pin_oe, pin_out}, 8'hC6);
    ctl_u.scan(1'b0, 32, 32'h0, got);
    check(got, {4'h1, 16'h5A5A, 11'h2A5, 1'b1});
    wrap_up();
  end
endmodule // bst_tap_bench
`default_nettype wire
